// ### core/psf_pkg.sv
package psf_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] PSF_ADDR_RAIL_VIEW = 8'h0a;
	localparam logic [7:0] PSF_ADDR_RAIL_CLEAR = 8'h0b;
	localparam logic [7:0] PSF_ADDR_TON_VIEW = 8'h24;
	localparam logic [7:0] PSF_ADDR_TON_CLEAR = 8'h25;

	// ==========================================================
	// Reset values
	localparam logic [7:0] PSF_RAIL_RST = 8'h10;
	localparam logic [7:0] PSF_TON_RST = 8'h00;
	localparam logic [7:0] PSF_UNMAPPED_DATA = 8'h00;

	// ==========================================================
	// Rail fault flag positions
	localparam int PSF_BIT_OVER_TEMP = 7;
	localparam int PSF_BIT_LOGIC_FAIL = 6;
	localparam int PSF_BIT_LOGIC_WARN = 5;
	localparam int PSF_BIT_PORT_RAIL = 4;
	localparam int PSF_BIT_PAIR_B_CUT = 3;
	localparam int PSF_BIT_PAIR_A_CUT = 2;
	localparam int PSF_BIT_SHUTDOWN = 1;
	localparam int PSF_BIT_UNUSED = 0;

	// ==========================================================
	// Turn-on failure fields
	localparam int PSF_NUM_PORTS = 4;
	localparam int PSF_CODE_W = 2;

	typedef enum logic [1:0] {
		PSF_TON_NONE = 2'b00,
		PSF_TON_BAD_DETECT = 2'b01,
		PSF_TON_CLASS_ERR = 2'b10,
		PSF_TON_NO_POWER = 2'b11
	} psf_ton_code_e;

	// ==========================================================
	// Comparator bundle from the analog monitors
	typedef struct packed {
		logic over_temp;
		logic logic_fail_below;
		logic logic_fail_above;
		logic logic_warn_below;
		logic logic_warn_above;
		logic port_rail_below;
		logic port_rail_above;
	} psf_rail_cmp_s;

	// Hysteresis states after reset: port rail counts as low until measured
	localparam logic [3:0] PSF_COND_RST = 4'h1;

	// Summary outputs toward the interrupt register
	typedef struct packed {
		logic rail_fault_summary;
		logic power_cut_summary;
		logic disconnect_summary;
		logic start_fault_summary;
	} psf_summary_s;

endpackage

// ### core/psf_flag_bank.sv
`timescale 1ns/1ns
`default_nettype none

module psf_flag_bank
	import psf_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic [WIDTH-1:0] load_mask,
	input wire logic [WIDTH-1:0] load_val,
	output logic [WIDTH-1:0] flags
);

	// ==========================================================
	// Elaboration check
	if (WIDTH < 1) begin : g_bad_width
		$error("psf_flag_bank: WIDTH must be at least 1");
	end

	// ==========================================================
	// Next value
	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] kept;
	logic [WIDTH-1:0] flags_nxt;

	// Loads land after the clear, so a same-cycle event survives
	assign kept = clear ? '0 : flags_r;
	assign flags_nxt = (kept & ~load_mask) | (load_val & load_mask);
	assign flags = flags_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flags_r <= RST_VAL;
		end else begin
			flags_r <= flags_nxt;
		end
	end

endmodule

`default_nettype wire

// ### core/psf_status_regs.sv
// Summary of operation
// - Rail flags at 0x0a view, 0x0b clearing
// - Bit 7 flags case over-temperature
// - Bit 6 logic rail fail, hysteresis
// - Bit 5 logic rail warning, hysteresis
// - Bit 4 port rail low, hysteresis
// - Bit 3 pair B power cut
// - Bit 2 pair A power cut
// - Bit 1 emergency shutdown occurred
// - Supply flags raise rail summary
// - Supply fault inhibits all port activity
// - Power cut flags raise power cut summary
// - Shutdown flag raises disconnect summary
// - Turn-on codes at 0x24 view, 0x25 clearing
// - Code: none, detect, class, power
// - Nonzero code raises start-fault summary
`timescale 1ns/1ns
`default_nettype none

module psf_status_regs
	import psf_pkg::*;
#(
	parameter int PORTS = PSF_NUM_PORTS
) (
	input wire logic clk,
	input wire logic nrst,
	input wire psf_rail_cmp_s rail_cmp,
	input wire logic pair_a_four_pair_power_cut,
	input wire logic pair_b_four_pair_power_cut,
	input wire logic emergency_shutdown,
	input wire logic [PORTS-1:0] turn_on_fail_stb,
	input wire logic [PORTS*PSF_CODE_W-1:0] turn_on_fail_code,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output psf_summary_s summary,
	output logic ports_inhibit
);

	// ==========================================================
	// Elaboration check
	if (PORTS * PSF_CODE_W != 8) begin : g_bad_ports
		$error("psf_status_regs: PORTS fields must fill one 8-bit register");
	end

	// ==========================================================
	// Helpers
	function automatic logic hyst(input logic state, input logic below, input logic above);
		logic r;
		r = state;
		if (below) begin
			r = 1'b1;
		end else if (above) begin
			r = 1'b0;
		end
		return r;
	endfunction

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ref_a);
		return a == ref_a;
	endfunction

	// ==========================================================
	// Comparator synchronisers
	psf_rail_cmp_s cmp_meta_r;
	psf_rail_cmp_s cmp_sync_r;

	// Analog comparators are asynchronous to clk
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmp_meta_r <= '0;
			cmp_sync_r <= '0;
		end else begin
			cmp_meta_r <= rail_cmp;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// ==========================================================
	// Condition states, hysteresis on all but thermal
	// Bits: 3 thermal, 2 logic fail, 1 logic warn, 0 port rail
	logic [3:0] cond_r;
	logic [3:0] cond_nxt;

	assign cond_nxt[3] = cmp_sync_r.over_temp;
	assign cond_nxt[2] = hyst(cond_r[2], cmp_sync_r.logic_fail_below,
		cmp_sync_r.logic_fail_above);
	assign cond_nxt[1] = hyst(cond_r[1], cmp_sync_r.logic_warn_below,
		cmp_sync_r.logic_warn_above);
	assign cond_nxt[0] = hyst(cond_r[0], cmp_sync_r.port_rail_below,
		cmp_sync_r.port_rail_above);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cond_r <= PSF_COND_RST;
		end else begin
			cond_r <= cond_nxt;
		end
	end

	// ==========================================================
	// Read decode
	logic rd_ok;
	logic hit_rail_view;
	logic hit_rail_clear;
	logic hit_ton_view;
	logic hit_ton_clear;
	logic clear_rail;
	logic clear_ton;

	assign rd_ok = reg_rd & ~reg_wr;
	assign hit_rail_view = rd_ok & addr_is(reg_addr, PSF_ADDR_RAIL_VIEW);
	assign hit_rail_clear = rd_ok & addr_is(reg_addr, PSF_ADDR_RAIL_CLEAR);
	assign hit_ton_view = rd_ok & addr_is(reg_addr, PSF_ADDR_TON_VIEW);
	assign hit_ton_clear = rd_ok & addr_is(reg_addr, PSF_ADDR_TON_CLEAR);
	assign clear_rail = hit_rail_clear;
	assign clear_ton = hit_ton_clear;

	// ==========================================================
	// Rail fault flags
	logic [7:0] rail_set;
	logic [7:0] rail_flags;

	// Level conditions re-assert every cycle, so a clear cannot hide them
	always_comb begin
		rail_set = '0;
		rail_set[PSF_BIT_OVER_TEMP] = cond_r[3];
		rail_set[PSF_BIT_LOGIC_FAIL] = cond_r[2];
		rail_set[PSF_BIT_LOGIC_WARN] = cond_r[1];
		rail_set[PSF_BIT_PORT_RAIL] = cond_r[0];
		rail_set[PSF_BIT_PAIR_B_CUT] = pair_b_four_pair_power_cut;
		rail_set[PSF_BIT_PAIR_A_CUT] = pair_a_four_pair_power_cut;
		rail_set[PSF_BIT_SHUTDOWN] = emergency_shutdown;
		rail_set[PSF_BIT_UNUSED] = 1'b0;
	end

	// Sets win over a clearing read
	psf_flag_bank #(
		.WIDTH(8),
		.RST_VAL(PSF_RAIL_RST)
	) u_rail_bank (
		.clk(clk),
		.nrst(nrst),
		.clear(clear_rail),
		.load_mask(rail_set),
		.load_val(rail_set),
		.flags(rail_flags)
	);

	// ==========================================================
	// Turn-on failure codes
	logic [7:0] ton_mask;
	logic [7:0] ton_val;
	logic [7:0] ton_flags;

	// Two-bit code per port, latest nonzero cause kept
	always_comb begin
		ton_mask = '0;
		ton_val = '0;
		for (int p = 0; p < PORTS; p++) begin
			if (turn_on_fail_stb[p] &&
				turn_on_fail_code[p*PSF_CODE_W +: PSF_CODE_W] != PSF_TON_NONE) begin
				ton_mask[p*PSF_CODE_W +: PSF_CODE_W] = 2'h3;
				ton_val[p*PSF_CODE_W +: PSF_CODE_W] =
					turn_on_fail_code[p*PSF_CODE_W +: PSF_CODE_W];
			end
		end
	end

	// Port 4 high field down to port 1 low
	psf_flag_bank #(
		.WIDTH(8),
		.RST_VAL(PSF_TON_RST)
	) u_ton_bank (
		.clk(clk),
		.nrst(nrst),
		.clear(clear_ton),
		.load_mask(ton_mask),
		.load_val(ton_val),
		.flags(ton_flags)
	);

	// ==========================================================
	// Read data
	logic [7:0] rdata_nxt;
	logic [7:0] rdata_r;
	logic rvalid_r;

	// Return contents from before the clear
	assign rdata_nxt = (hit_rail_view | hit_rail_clear) ? rail_flags :
		(hit_ton_view | hit_ton_clear) ? ton_flags : PSF_UNMAPPED_DATA;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= PSF_UNMAPPED_DATA;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rd_ok;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	// ==========================================================
	// Summaries and port inhibit
	psf_summary_s summary_nxt;
	psf_summary_s summary_r;
	logic inhibit_r;
	logic inhibit_nxt;

	assign summary_nxt.rail_fault_summary = |rail_flags[PSF_BIT_OVER_TEMP:PSF_BIT_PORT_RAIL];
	assign summary_nxt.power_cut_summary = rail_flags[PSF_BIT_PAIR_B_CUT] |
		rail_flags[PSF_BIT_PAIR_A_CUT];
	assign summary_nxt.disconnect_summary = rail_flags[PSF_BIT_SHUTDOWN];
	assign summary_nxt.start_fault_summary = |ton_flags;
	// Follows the live condition, not the sticky flag
	assign inhibit_nxt = |cond_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			summary_r <= '0;
			inhibit_r <= 1'b1;
		end else begin
			summary_r <= summary_nxt;
			inhibit_r <= inhibit_nxt;
		end
	end

	assign summary = summary_r;
	assign ports_inhibit = inhibit_r;

endmodule

`default_nettype wire

// ### testbench/psf_status_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module psf_status_regs_asserts
	import psf_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire psf_rail_cmp_s rail_cmp,
	input wire logic pair_a_four_pair_power_cut,
	input wire logic pair_b_four_pair_power_cut,
	input wire logic emergency_shutdown,
	input wire logic [3:0] turn_on_fail_stb,
	input wire logic [7:0] turn_on_fail_code,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire psf_summary_s summary,
	input wire logic ports_inhibit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	wire logic take = reg_rd && !reg_wr;
	wire logic [3:0] code_nz = {|turn_on_fail_code[7:6], |turn_on_fail_code[5:4],
		|turn_on_fail_code[3:2], |turn_on_fail_code[1:0]};
	wire logic ton_hit = |(turn_on_fail_stb & code_nz);
	// ==========================================================
	// Read port
	a_read_answer: assert property (take |=> reg_rvalid)
		else $error("read not answered");
	a_no_answer: assert property (!take |=> !reg_rvalid)
		else $error("answer without read");
	a_rail_bit0: assert property (reg_rvalid && $past(reg_addr[7:1]) == 7'h05
		|-> !reg_rdata[0]) else $error("unused bit set");
	// ==========================================================
	// Summaries and inhibit
	a_cut_summary: assert property (
		(pair_a_four_pair_power_cut || pair_b_four_pair_power_cut)
		|-> ##2 summary.power_cut_summary) else $error("power cut summary missing");
	a_shut_summary: assert property (emergency_shutdown |-> ##2 summary.disconnect_summary)
		else $error("disconnect summary missing");
	a_start_summary: assert property (ton_hit |-> ##2 summary.start_fault_summary)
		else $error("start summary missing");
	a_temp_inhibit: assert property (rail_cmp.over_temp [*6] |-> ports_inhibit)
		else $error("ports not inhibited");
	a_temp_summary: assert property (rail_cmp.over_temp [*6] |-> summary.rail_fault_summary)
		else $error("rail summary missing");
endmodule
`default_nettype wire

// ### testbench/psf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module psf_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
	end
	// One-cycle strobe; answer is registered, so sample a cycle later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask
	task automatic wr(input logic [7:0] a);
		@(negedge clk);
		reg_addr = a;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	// Read raised together with write is refused
	task automatic rw(input logic [7:0] a, output logic v);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		v = reg_rvalid;
	endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import psf_pkg::*;
;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	psf_rail_cmp_s cmp = '0;
	logic cut_a = 1'b0;
	logic cut_b = 1'b0;
	logic shut = 1'b0;
	logic [3:0] stb = '0;
	logic [7:0] code = '0;
	logic [7:0] addr;
	logic rd;
	logic wr;
	logic [7:0] rdata;
	logic rvalid;
	psf_summary_s summ;
	logic inhibit;
	logic [7:0] d;
	logic v;
	int fail_count = 0;
	int total_checks = 0;
	int bl[4] = '{6, 5, 3, 1};
	int ab[4] = '{6, 4, 2, 0};
	always #5 clk = ~clk;
	psf_host_model host (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_rdata(rdata), .reg_rvalid(rvalid));
	psf_status_regs uut (.clk(clk), .nrst(nrst), .rail_cmp(cmp),
		.pair_a_four_pair_power_cut(cut_a), .pair_b_four_pair_power_cut(cut_b),
		.emergency_shutdown(shut), .turn_on_fail_stb(stb), .turn_on_fail_code(code),
		.reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .summary(summ), .ports_inhibit(inhibit));
	// ==========================================================
	// Checking
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic end_sim;
		$display("Checks %0d, errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Whole run is under two hundred cycles
	initial begin
		#50000;
		fail_count++;
		end_sim();
	end
	// ==========================================================
	// Scenarios
	initial begin
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		chk(8'(inhibit), 8'h01);
		rdc(8'h0a, 8'h10);
		rdc(8'h24, 8'h00);
		rdc(8'h33, 8'h00);
		cmp.port_rail_above = 1'b1;
		idle(6);
		cmp.port_rail_above = 1'b0;
		rdc(8'h0b, 8'h10);
		rdc(8'h0a, 8'h00);
		chk(8'(summ.rail_fault_summary), 8'h00);
		for (int i = 0; i < 4; i++) begin
			cmp[bl[i]] = 1'b1;
			idle(6);
			chk(8'(inhibit), 8'h01);
			chk(8'(summ.rail_fault_summary), 8'h01);
			cmp[bl[i]] = 1'b0;
			idle(6);
			// Hysteresis: flag stays live until the upper level is seen
			if (i > 0) begin
				rdc(8'h0b, 8'h80 >> i);
				rdc(8'h0a, 8'h80 >> i);
				cmp[ab[i]] = 1'b1;
				idle(6);
				cmp[ab[i]] = 1'b0;
			end
			rdc(8'h0b, 8'h80 >> i);
			rdc(8'h0a, 8'h00);
		end
		chk(8'(inhibit), 8'h00);
		for (int j = 0; j < 3; j++) begin
			{cut_b, cut_a, shut} = 3'b100 >> j;
			idle(1);
			{cut_b, cut_a, shut} = 3'b000;
			idle(2);
			chk(8'(j < 2 ? summ.power_cut_summary : summ.disconnect_summary), 8'h01);
			host.wr(8'h0b);
			host.rw(8'h0b, v);
			chk(8'(v), 8'h00);
			rdc(8'h0a, 8'h08 >> j);
			rdc(8'h0b, 8'h08 >> j);
			rdc(8'h0a, 8'h00);
			chk(8'({summ.power_cut_summary, summ.disconnect_summary}), 8'h00);
		end
		// Event at the very edge of a clearing read must survive
		shut = 1'b1;
		host.rd(8'h0b, d);
		shut = 1'b0;
		chk(d, 8'h02);
		rdc(8'h0a, 8'h02);
		for (int p = 0; p < 4; p++) begin
			stb = 4'(1 << p);
			code = {4{2'(p)}};
			idle(1);
		end
		stb = '0;
		idle(2);
		chk(8'(summ.start_fault_summary), 8'h01);
		rdc(8'h24, 8'he4);
		stb = 4'h8;
		code = 8'h40;
		idle(1);
		stb = '0;
		rdc(8'h25, 8'h64);
		rdc(8'h24, 8'h00);
		chk(8'(summ.start_fault_summary), 8'h00);
		end_sim();
	end
endmodule
bind psf_status_regs psf_status_regs_asserts chk_i (.clk(clk), .nrst(nrst),
	.rail_cmp(rail_cmp), .pair_a_four_pair_power_cut(pair_a_four_pair_power_cut),
	.pair_b_four_pair_power_cut(pair_b_four_pair_power_cut),
	.emergency_shutdown(emergency_shutdown), .turn_on_fail_stb(turn_on_fail_stb),
	.turn_on_fail_code(turn_on_fail_code), .reg_addr(reg_addr), .reg_rd(reg_rd),
	.reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.summary(summary), .ports_inhibit(ports_inhibit));
`default_nettype wire
